// ===== rtl/fdp_discovery.sv
// serial capability discovery table with power-on state
// Operation
// - minimum erase size reads 01 (4KB), write granularity bit reads 1
// - volatile status write-enable field reads 00, not applicable
// - bits 15:8 of first parameter dword hold 4KB erase opcode 20h
// - bit 16 reports single address, dual data fast read supported
// - addressing width field reads 00, three address bytes
// - bits 19, 20 and 21 read zero
// - continuous program and parallel bits read 0, pause input bit reads 1
// - single address quad output read bit reads 0
// - deep power-down supported bit reads 1
// - sector group protect 1, block protect and boot protect 0
// - 64KB block erase supported 1, 32KB block erase 0
// - after power-up the device sits in standby, not deep power-down
// - write enable latch cleared at power-up
// - delivered array bytes read FFh, status register reads 00h
`timescale 1ns/100ps
module fdp_discovery
   import fdp_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire logic       cs_n,
   input  wire logic       sclk,
   input  wire logic       si,
   output logic            so_q,
   output logic            so_oe_q,
   output logic            standby_q,
   output logic            deep_power_down_q,
   output logic            write_enable_latch_q,
   output logic [7:0]      status_q
);

   // ----------------------------------------------------------------
   // pin synchronisation and edge finding
   // ----------------------------------------------------------------
   fdp_pins_t pins_async;
   fdp_pins_t pins;
   logic      sclk_prev_q;
   logic      armed_q;
   logic [FDP_SYNC_STAGES-1:0] flush_q;

   assign pins_async = '{cs_n: cs_n, sclk: sclk, si: si};

   fdp_sync #(
      .W        ($bits(fdp_pins_t))
   ) u_sync (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .async_in (pins_async),
      .sync_out (pins)
   );

   wire sel      = ~pins.cs_n & armed_q;
   wire sclk_re  = pins.sclk & ~sclk_prev_q;
   wire sclk_fe  = ~pins.sclk & sclk_prev_q;
   wire bit_take = sel & sclk_re;
   wire bit_give = sel & sclk_fe;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         // matches the synchroniser's reset level, so release shows no false edge
         sclk_prev_q <= 1'b1;
      end else begin
         sclk_prev_q <= pins.sclk;
      end
   end

   // the synchroniser shows its reset level until both stages hold the pin
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         flush_q <= '0;
      end else begin
         flush_q <= {flush_q[FDP_SYNC_STAGES-2:0], 1'b1};
      end
   end

   // a frame already running when reset lifts is ignored until a deselect
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         armed_q <= 1'b0;
      end else if (pins.cs_n && flush_q[FDP_SYNC_STAGES-1]) begin
         armed_q <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // table contents
   // ----------------------------------------------------------------
   logic [31:0] basic_flash_params;
   logic [31:0] feature_capabilities;
   logic [31:0] supply_voltages;

   always_comb begin
      basic_flash_params = '0;
      basic_flash_params[FDP_ERASE_SIZE_LSB +: 2] = FDP_ERASE_SIZE_4KB;
      basic_flash_params[FDP_WRITE_GRAN_BIT]      = 1'b1;
      basic_flash_params[FDP_VOL_WREN_LSB +: 2]   = FDP_VOL_WREN_NA;
      basic_flash_params[FDP_ERASE_OP_LSB +: 8]   = FDP_ERASE_4KB_OP;
      basic_flash_params[FDP_DUAL_OUT_BIT]        = 1'b1;
      basic_flash_params[FDP_ADDR_BYTES_LSB +: 2] = FDP_ADDR_3BYTE;
      basic_flash_params[FDP_DTR_BIT]             = 1'b0;
      basic_flash_params[FDP_DUAL_IO_BIT]         = 1'b0;
      basic_flash_params[FDP_QUAD_IO_BIT]         = 1'b0;
   end

   always_comb begin
      feature_capabilities = '0;
      feature_capabilities[FDP_PAUSE_BIT]      = 1'b1;
      feature_capabilities[FDP_PARALLEL_BIT]   = 1'b0;
      feature_capabilities[FDP_CONT_PROG_BIT]  = 1'b0;
      feature_capabilities[FDP_QUAD_OUT_BIT]   = 1'b0;
      feature_capabilities[FDP_DEEP_PD_BIT]    = 1'b1;
      feature_capabilities[FDP_OTP_BIT]        = 1'b1;
      feature_capabilities[FDP_SECTOR_GRP_BIT] = 1'b1;
      feature_capabilities[FDP_BLOCK_PROT_BIT] = 1'b0;
      feature_capabilities[FDP_BOOT_PROT_BIT]  = 1'b0;
      feature_capabilities[FDP_ERASE_64K_BIT]  = 1'b1;
      feature_capabilities[FDP_ERASE_32K_BIT]  = 1'b0;
   end

   assign supply_voltages = {FDP_SUPPLY_MIN_VAL, FDP_SUPPLY_MAX_VAL};

   // ----------------------------------------------------------------
   // frame decoder
   // ----------------------------------------------------------------
   fdp_state_t  state_q;
   logic [2:0]  bit_cnt_q;
   logic [1:0]  addr_idx_q;
   logic [7:0]  in_sr_q;
   logic [7:0]  out_sr_q;
   logic [23:0] addr_q;
   logic        array_rd_q;

   wire [7:0]  in_byte   = {in_sr_q[6:0], pins.si};
   wire        byte_done = bit_take & (bit_cnt_q == FDP_BIT_LAST);
   wire [23:0] look_addr = (state_q == FDP_ST_DATA) ? 24'(addr_q + 24'h000001) : addr_q;
   wire [23:0] dw_base   = {look_addr[23:2], 2'b00};
   wire [4:0]  lane_sh   = {look_addr[1:0], 3'b000};

   wire [31:0] dw_sel =
      (dw_base == FDP_BASIC_FLASH_PARAMS_OFS)   ? basic_flash_params   :
      (dw_base == FDP_FLASH_SIZE_BITS_OFS)      ? FDP_FLASH_SIZE_BITS_VAL :
      (dw_base == FDP_SUPPLY_MAX_VOLTAGE_OFS)   ? supply_voltages      :
      (dw_base == FDP_FEATURE_CAPABILITIES_OFS) ? feature_capabilities : '0;

   // the array itself lives elsewhere; here it reads as delivered
   wire [7:0] tbl_byte  = 8'(dw_sel >> lane_sh);
   wire [7:0] next_byte = array_rd_q ? FDP_ERASED_BYTE : tbl_byte;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         bit_cnt_q <= 3'h0;
         in_sr_q   <= 8'h00;
      end else if (!sel) begin
         bit_cnt_q <= 3'h0;
      end else if (bit_take) begin
         bit_cnt_q <= 3'(bit_cnt_q + 3'h1);
         in_sr_q   <= in_byte;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_q    <= FDP_ST_CMD;
         addr_idx_q <= 2'h0;
         addr_q     <= 24'h000000;
         array_rd_q <= 1'b0;
      end else if (!sel) begin
         state_q    <= FDP_ST_CMD;
         addr_idx_q <= 2'h0;
      end else if (byte_done) begin
         case (state_q)
            FDP_ST_CMD: begin
               array_rd_q <= (in_byte == FDP_ARRAY_READ_CMD);
               if (in_byte == FDP_CAPABILITY_TABLE_READ_CMD ||
                   in_byte == FDP_ARRAY_READ_CMD) begin
                  state_q <= FDP_ST_ADDR;
               end else begin
                  state_q <= FDP_ST_IGNORE;
               end
            end
            FDP_ST_ADDR: begin
               addr_q     <= {addr_q[15:0], in_byte};
               addr_idx_q <= 2'(addr_idx_q + 2'h1);
               if (addr_idx_q == FDP_ADDR_BYTES_LAST) begin
                  state_q <= array_rd_q ? FDP_ST_DATA : FDP_ST_DUMMY;
               end
            end
            FDP_ST_DUMMY: begin
               state_q <= FDP_ST_DATA;
            end
            FDP_ST_DATA: begin
               addr_q <= look_addr; // table walks forward byte by byte
            end
            default: begin
               state_q <= FDP_ST_IGNORE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // output shifter: loaded on the last rising edge of a byte,
   // presented on falling edges so the host samples on rising ones
   // ----------------------------------------------------------------
   wire load_out = byte_done & ((state_q == FDP_ST_DUMMY) | (state_q == FDP_ST_DATA) |
                   (state_q == FDP_ST_ADDR && addr_idx_q == FDP_ADDR_BYTES_LAST && array_rd_q));
   wire [7:0] load_val = (state_q == FDP_ST_ADDR) ? FDP_ERASED_BYTE : next_byte;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         out_sr_q <= 8'h00;
         so_q     <= 1'b0;
         so_oe_q  <= 1'b0;
      end else if (!sel) begin
         so_oe_q  <= 1'b0;
      end else if (load_out) begin
         out_sr_q <= load_val;
      end else if (bit_give && state_q == FDP_ST_DATA) begin
         so_q     <= out_sr_q[7];
         out_sr_q <= {out_sr_q[6:0], 1'b0};
         so_oe_q  <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // power-on state
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         standby_q            <= 1'b0;
         deep_power_down_q    <= 1'b0;
         write_enable_latch_q <= FDP_WEL_RST;
         status_q             <= FDP_STATUS_RST;
      end else begin
         standby_q            <= 1'b1;
         deep_power_down_q    <= 1'b0;
         write_enable_latch_q <= FDP_WEL_RST;
         status_q             <= {7'h00, write_enable_latch_q};
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   sequence s_dummy_done;
      byte_done && state_q == FDP_ST_DUMMY;
   endsequence

   sequence s_first_give;
      bit_give && state_q == FDP_ST_DATA;
   endsequence

   a_param_erase_gran: assert property (@(posedge ref_clk) disable iff (rst)
      basic_flash_params[2:0] == 3'b101 && basic_flash_params[4:3] == 2'b00)
      else $error("erase size or write granularity field wrong");

   a_param_opcode_modes: assert property (@(posedge ref_clk) disable iff (rst)
      basic_flash_params == 32'h00012005)
      else $error("basic flash parameter dword wrong");

   a_caps_dword_val: assert property (@(posedge ref_clk) disable iff (rst)
      feature_capabilities == 32'h00013820)
      else $error("feature capability dword wrong");

   a_caps_size_read: assert property (@(posedge ref_clk) disable iff (rst)
      (state_q == FDP_ST_DATA && !array_rd_q && look_addr == 24'h000025) |->
      next_byte == 8'hFF)
      else $error("flash size byte wrong");

   a_reserved_zero: assert property (@(posedge ref_clk) disable iff (rst)
      (state_q == FDP_ST_DATA && !array_rd_q && look_addr[23:6] != 18'h0) |->
      next_byte == 8'h00)
      else $error("reserved table byte not zero");

   a_power_on_state: assert property (@(posedge ref_clk)
      $fell(rst) |-> !write_enable_latch_q && !deep_power_down_q && status_q == 8'h00
      ##1 standby_q)
      else $error("power-on state wrong");

   a_status_clear: assert property (@(posedge ref_clk) disable iff (rst)
      status_q == 8'h00 && !deep_power_down_q)
      else $error("status or power-down state wrong");

   a_dummy_load: assert property (@(posedge ref_clk) disable iff (rst)
      s_dummy_done |=> out_sr_q == $past(next_byte) && state_q == FDP_ST_DATA)
      else $error("first table byte not loaded after dummy");

   a_first_bit_out: assert property (@(posedge ref_clk) disable iff (rst)
      s_first_give |=> so_oe_q && so_q == $past(out_sr_q[7]))
      else $error("data bit not driven on falling edge");

   a_deselect_float: assert property (@(posedge ref_clk) disable iff (rst)
      (pins.cs_n || !armed_q) |=> !so_oe_q ##1 state_q == FDP_ST_CMD)
      else $error("output driven while deselected");

   a_arm_after_flush: assert property (@(posedge ref_clk) disable iff (rst)
      !flush_q[FDP_SYNC_STAGES-1] |=> !armed_q)
      else $error("frame armed from reset level of chip select");

   a_oe_only_data: assert property (@(posedge ref_clk) disable iff (rst)
      so_oe_q |-> state_q == FDP_ST_DATA)
      else $error("output driven outside the data phase");

   a_ignore_quiet: assert property (@(posedge ref_clk) disable iff (rst)
      state_q == FDP_ST_IGNORE |-> !so_oe_q)
      else $error("output driven for a refused opcode");

endmodule : fdp_discovery

// ===== rtl/fdp_pkg.sv
// package of constants and types for the capability discovery table block
package fdp_pkg;

   // ----------------------------------------------------------------
   // link framing
   // ----------------------------------------------------------------
   localparam logic [7:0] FDP_CAPABILITY_TABLE_READ_CMD = 8'h5A;
   localparam logic [7:0] FDP_ARRAY_READ_CMD            = 8'h03;
   localparam logic [1:0] FDP_ADDR_BYTES_LAST           = 2'h2;  // three address bytes
   localparam logic [2:0] FDP_BIT_LAST                  = 3'h7;
   localparam int         FDP_SYNC_STAGES               = 2;

   // ----------------------------------------------------------------
   // table offsets (byte addresses on the link)
   // ----------------------------------------------------------------
   localparam logic [23:0] FDP_BASIC_FLASH_PARAMS_OFS   = 24'h000020;
   localparam logic [23:0] FDP_FLASH_SIZE_BITS_OFS      = 24'h000024;
   localparam logic [23:0] FDP_SUPPLY_MAX_VOLTAGE_OFS   = 24'h000030;
   localparam logic [23:0] FDP_SUPPLY_MIN_VOLTAGE_OFS   = 24'h000032;
   localparam logic [23:0] FDP_FEATURE_CAPABILITIES_OFS = 24'h000034;

   // ----------------------------------------------------------------
   // basic flash parameter fields
   // ----------------------------------------------------------------
   localparam int         FDP_ERASE_SIZE_LSB  = 0;
   localparam logic [1:0] FDP_ERASE_SIZE_4KB  = 2'h1;
   localparam int         FDP_WRITE_GRAN_BIT  = 2;
   localparam int         FDP_VOL_WREN_LSB    = 3;
   localparam logic [1:0] FDP_VOL_WREN_NA     = 2'h0;
   localparam int         FDP_ERASE_OP_LSB    = 8;
   localparam logic [7:0] FDP_ERASE_4KB_OP    = 8'h20;
   localparam int         FDP_DUAL_OUT_BIT    = 16;
   localparam int         FDP_ADDR_BYTES_LSB  = 17;
   localparam logic [1:0] FDP_ADDR_3BYTE      = 2'h0;
   localparam int         FDP_DTR_BIT         = 19;
   localparam int         FDP_DUAL_IO_BIT     = 20;
   localparam int         FDP_QUAD_IO_BIT     = 21;

   // ----------------------------------------------------------------
   // feature capability fields
   // ----------------------------------------------------------------
   localparam int FDP_PAUSE_BIT       = 5;
   localparam int FDP_PARALLEL_BIT    = 8;
   localparam int FDP_QUAD_OUT_BIT    = 9;
   localparam int FDP_CONT_PROG_BIT   = 10;
   localparam int FDP_DEEP_PD_BIT     = 11;
   localparam int FDP_OTP_BIT         = 12;
   localparam int FDP_SECTOR_GRP_BIT  = 13;
   localparam int FDP_BLOCK_PROT_BIT  = 14;
   localparam int FDP_BOOT_PROT_BIT   = 15;
   localparam int FDP_ERASE_64K_BIT   = 16;
   localparam int FDP_ERASE_32K_BIT   = 17;

   // ----------------------------------------------------------------
   // table values and power-on values
   // ----------------------------------------------------------------
   localparam logic [31:0] FDP_FLASH_SIZE_BITS_VAL   = 32'h007FFFFF;
   localparam logic [15:0] FDP_SUPPLY_MAX_VAL        = 16'h3600;
   localparam logic [15:0] FDP_SUPPLY_MIN_VAL        = 16'h2700;
   localparam logic [7:0]  FDP_ERASED_BYTE           = 8'hFF;
   localparam logic [7:0]  FDP_STATUS_RST            = 8'h00;
   localparam logic        FDP_WEL_RST               = 1'b0;
   localparam logic [7:0]  FDP_RESERVED_BYTE         = 8'h00;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic cs_n;
      logic sclk;
      logic si;
   } fdp_pins_t;

   typedef enum logic [2:0] {
      FDP_ST_CMD,
      FDP_ST_ADDR,
      FDP_ST_DUMMY,
      FDP_ST_DATA,
      FDP_ST_IGNORE
   } fdp_state_t;

endpackage : fdp_pkg

// ===== rtl/fdp_sync.sv
// two flip-flop synchroniser for a bundle of link pins
`timescale 1ns/100ps
module fdp_sync
   import fdp_pkg::*;
#(
   parameter int W = 3
) (
   input  wire logic         ref_clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   logic [W-1:0] meta_q;

   // only the second stage is visible to the rest of the block
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         meta_q   <= '1;
         sync_out <= '1;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule : fdp_sync

// ===== sim/fdp_host_model.sv
// serial host model that reads the capability table over the link
`timescale 1ns/100ps
module fdp_host_model
   import fdp_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic so_q,
   input  wire logic so_oe_q,
   output fdp_pins_t pins
);
   logic [7:0] rd [0:31];
   int         oe_bad;

   // -----------------------------------------------------------------
   // idle state: deselected with the link clock parked low
   // -----------------------------------------------------------------
   initial begin
      pins   = '{cs_n: 1'b1, sclk: 1'b0, si: 1'b0};
      oe_bad = 0;
   end

   // half a link period, 40 ns, launched just after a ref_clk edge
   task automatic half();
      repeat (4) @(posedge ref_clk);
      #1;
   endtask : half

   // mode 0, msb first; so is taken on the rising link edge
   task automatic shift(input logic [7:0] tx, input bit chk, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         pins.si = tx[i];
         half();
         pins.sclk = 1'b1;
         // an undriven line is read as the inverse so it never passes by luck
         rx[i] = so_oe_q ? so_q : ~so_q;
         if (chk && so_oe_q !== 1'b1) oe_bad++;
         half();
         pins.sclk = 1'b0;
      end
   endtask : shift

   // -----------------------------------------------------------------
   // one whole frame: opcode, three address bytes, optional dummy, data
   // -----------------------------------------------------------------
   task automatic frame(input logic [7:0] op, input logic [23:0] a, input bit dmy,
                        input int n, input bit chk);
      logic [7:0] junk;
      pins.cs_n = 1'b0;
      half();
      shift(op, 1'b0, junk);
      shift(a[23:16], 1'b0, junk);
      shift(a[15:8], 1'b0, junk);
      shift(a[7:0], 1'b0, junk);
      if (dmy) shift(8'h00, 1'b0, junk);
      for (int k = 0; k < n; k++) shift(8'hA5 ^ k[7:0], chk, rd[k]);
      half();
      pins.cs_n = 1'b1;
      pins.si   = ~pins.si;
      // deselect of three ref_clk cycles between frames; the device needs only one
      repeat (3) @(posedge ref_clk);
      #1;
   endtask : frame
endmodule : fdp_host_model

// ===== sim/fdp_discovery_tb_top.sv
// self-checking testbench for the capability discovery table
`timescale 1ns/100ps
module fdp_discovery_tb_top;
   import fdp_pkg::*;
   logic       ref_clk;
   logic       rst;
   fdp_pins_t  pins;
   logic       so_q;
   logic       so_oe_q;
   logic       standby_q;
   logic       deep_power_down_q;
   logic       write_enable_latch_q;
   logic [7:0] status_q;
   int         failures;
   int         tests_run;
   int         oe_cnt;

   fdp_discovery dut (.ref_clk(ref_clk), .rst(rst), .cs_n(pins.cs_n), .sclk(pins.sclk),
      .si(pins.si), .so_q(so_q), .so_oe_q(so_oe_q), .standby_q(standby_q),
      .deep_power_down_q(deep_power_down_q), .write_enable_latch_q(write_enable_latch_q),
      .status_q(status_q));
   fdp_host_model host (.ref_clk(ref_clk), .so_q(so_q), .so_oe_q(so_oe_q), .pins(pins));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   always @(negedge ref_clk) if (so_oe_q === 1'b1) oe_cnt++;

   // -----------------------------------------------------------------
   // shared helpers
   // -----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask : chk

   // table bytes sit little-endian inside each dword
   function automatic logic [31:0] dw(input int b);
      return {host.rd[b+3], host.rd[b+2], host.rd[b+1], host.rd[b]};
   endfunction : dw

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : end_sim

   // -----------------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------------
   task automatic test_power_on();
      rst = 1'b1;
      repeat (10) @(posedge ref_clk);
      #1;
      chk({standby_q, so_oe_q, status_q}, 10'h000, "outputs in reset");
      rst = 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
      chk(standby_q, 1'b1, "standby after power-on");
      chk(deep_power_down_q, 1'b0, "deep power-down after power-on");
      chk(write_enable_latch_q, 1'b0, "write enable latch");
      chk(status_q, 8'h00, "status register");
      // host holds off commands for a while after power-up
      repeat (5) @(posedge ref_clk);
      #1;
      $display("test power_on done");
   endtask : test_power_on

   task automatic test_table();
      logic [31:0] d;
      host.oe_bad = 0;
      host.frame(8'h5A, 24'h000020, 1'b1, 24, 1'b1);
      chk(host.oe_bad, 0, "output enable during data");
      d = dw(0);
      chk(d[1:0], 2'h1, "minimum erase size");
      chk(d[2], 1'b1, "write granularity");
      chk(d[4:3], 2'h0, "volatile write enable");
      chk(d[15:8], 8'h20, "4KB erase opcode");
      chk(d[16], 1'b1, "dual output read");
      chk(d[18:17], 2'h0, "address bytes");
      chk(d[21:19], 3'h0, "unsupported read modes");
      chk({d[31:22], d[7:5]}, 13'h0000, "reserved first dword");
      chk(dw(4), 32'h007FFFFF, "flash size");
      chk(dw(8), 32'h00000000, "second table low");
      chk(dw(12), 32'h00000000, "second table high");
      chk(dw(16), 32'h27003600, "supply range");
      d = dw(20);
      chk({d[10], d[8], d[5]}, 3'b001, "program, parallel, pause");
      chk(d[9], 1'b0, "quad output read");
      chk(d[11], 1'b1, "deep power-down support");
      chk(d[15:13], 3'b001, "protection bits");
      chk(d[17:16], 2'b01, "block erase sizes");
      chk({d[31:18], d[7:6], d[4:0]}, 21'h000000, "reserved capability bits");
      $display("test table done");
   endtask : test_table

   task automatic test_edges();
      // back-to-back frames across both ends of the table
      host.frame(8'h5A, 24'h00001F, 1'b1, 2, 1'b1);
      chk({host.rd[1], host.rd[0]}, 16'h0500, "header edge");
      // runs past 40h so the read walks into the undefined space
      host.frame(8'h5A, 24'h000036, 1'b1, 12, 1'b1);
      chk(dw(0), 32'h00000001, "end of table");
      chk(dw(4) | dw(8), 32'h00000000, "beyond the table");
      chk(so_oe_q, 1'b0, "output released after frame");
      $display("test edges done");
   endtask : test_edges

   task automatic test_refused();
      oe_cnt = 0;
      host.frame(8'h9F, 24'h000020, 1'b1, 2, 1'b0);
      chk(oe_cnt, 0, "unknown opcode drives output");
      host.frame(8'h03, 24'h000100, 1'b0, 3, 1'b1);
      for (int k = 0; k < 3; k++) chk(host.rd[k], 8'hFF, "erased array byte");
      $display("test refused done");
   endtask : test_refused

   // -----------------------------------------------------------------
   // main sequence and watchdog
   // -----------------------------------------------------------------
   initial begin
      rst       = 1'b1;
      failures  = 0;
      tests_run = 0;
      oe_cnt    = 0;
      test_power_on();
      test_table();
      test_edges();
      test_refused();
      // second reset in mid-run must bring back the power-on state
      test_power_on();
      test_table();
      end_sim();
   end

   initial begin
      // about 6200 cycles of traffic, so 50000 cycles means a hang
      #500000;
      failures++;
      $display("wrong value at %0t: watchdog expired", $time);
      end_sim();
   end
endmodule : fdp_discovery_tb_top
